// >>> arc_ctrl.sv
// Control registers of the isochronous rate converters
//
// Summary of operation
// - Converter two high rate code at 14:11
// - Converter two low rate code at 14:11
// - Interpolation enables at bits 15 to 12, converter two only
// - Decimation enables at bits 9 to 6, converter one at bits 8 to 6
// - Notch enable at bit 0
// - Refuse new path enable when underclocked
// - Converter two notch configured from selected rates automatically
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
`include "arc_defs.svh"
module arc_ctrl
  import arc_pkg::*;
(
  // Clock and reset
  input  wire logic                   sys_clk_i,
  input  wire logic                   reset_i,
  // Register port
  input  wire logic [`ARC_ADDR_W-1:0] reg_addr_i,
  input  wire logic [15:0]            reg_wdata_i,
  input  wire logic                   reg_wr_i,
  input  wire logic                   reg_rd_i,
  output logic      [15:0]            reg_rdata_o,
  // Clock headroom check from the clocking block
  input  wire logic                   clk_sufficient_i,
  // Converter controls
  output arc_path_s                   conv1_path_o,
  output arc_path_s                   conv2_path_o,
  output arc_notch_cfg_s              conv2_notch_cfg_o,
  output logic                        underclock_err_o
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Enables may only rise when the clock can carry them
  function automatic logic [15:0] gate_enables(input logic [15:0] old_v,
                                               input logic [15:0] new_v,
                                               input logic        ok);
    gate_enables = ok ? new_v : (new_v & old_v);
  endfunction : gate_enables

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  // Reserved rate codes are stored as written; software keeps them out
  logic [3:0]  high_q, high_d;
  logic [3:0]  low_q, low_d;
  logic [15:0] c1_en_q, c1_en_d;
  logic [15:0] c2_en_q, c2_en_d;
  logic [15:0] rdata_q, rdata_d;
  logic        err_q, err_d;
  logic [15:0] wr_c1, wr_c2;

  always_comb begin
    high_d  = high_q;
    low_d   = low_q;
    c1_en_d = c1_en_q;
    c2_en_d = c2_en_q;
    err_d   = 1'b0;
    rdata_d = 16'h0000;
    wr_c1   = reg_wdata_i & `ARC_C1_EN_MASK;
    wr_c2   = reg_wdata_i & `ARC_C2_EN_MASK;
    if (reg_wr_i) begin
      case (reg_addr_i)
        `ARC_OFF_C2_HIGH: begin
          high_d = reg_wdata_i[`ARC_RATE_MSB:`ARC_RATE_LSB];
        end
        `ARC_OFF_C2_LOW: begin
          low_d = reg_wdata_i[`ARC_RATE_MSB:`ARC_RATE_LSB];
        end
        // Clearing always passes so software can shed load
        // converter one enables, refusal
        `ARC_OFF_C1_EN: begin
          c1_en_d = gate_enables(c1_en_q, wr_c1, clk_sufficient_i);
          err_d   = !clk_sufficient_i && ((wr_c1 & ~c1_en_q) != 16'h0000);
        end
        `ARC_OFF_C2_EN: begin
          c2_en_d = gate_enables(c2_en_q, wr_c2, clk_sufficient_i);
          err_d   = !clk_sufficient_i && ((wr_c2 & ~c2_en_q) != 16'h0000);
        end
        default: begin
        end
      endcase
    end
    if (reg_rd_i) begin
      // readback, unmapped and undefined bits zero
      case (reg_addr_i)
        `ARC_OFF_C2_HIGH: rdata_d = {1'b0, high_q, 11'h000};
        `ARC_OFF_C2_LOW:  rdata_d = {1'b0, low_q, 11'h000};
        `ARC_OFF_C1_EN:   rdata_d = c1_en_q;
        `ARC_OFF_C2_EN:   rdata_d = c2_en_q;
        default:          rdata_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      high_q  <= `ARC_RATE_RST;
      low_q   <= `ARC_RATE_RST;
      c1_en_q <= `ARC_EN_RST;
      c2_en_q <= `ARC_EN_RST;
      rdata_q <= 16'h0000;
      err_q   <= 1'b0;
    end else begin
      high_q  <= high_d;
      low_q   <= low_d;
      c1_en_q <= c1_en_d;
      c2_en_q <= c2_en_d;
      rdata_q <= rdata_d;
      err_q   <= err_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata_o      = rdata_q;
  assign underclock_err_o = err_q;
  assign conv1_path_o = '{interp_en: 4'h0,
                          decim_en:  {1'b0,
                                      c1_en_q[`ARC_C1_DEC_MSB:`ARC_DEC_LSB]},
                          notch_en:  c1_en_q[`ARC_NOTCH_BIT]};
  assign conv2_path_o = '{interp_en: c2_en_q[`ARC_INT_MSB:`ARC_INT_LSB],
                          decim_en:  c2_en_q[`ARC_DEC_MSB:`ARC_DEC_LSB],
                          notch_en:  c2_en_q[`ARC_NOTCH_BIT]};
  // notch follows the selected rates, no coefficients
  assign conv2_notch_cfg_o = '{high_rate: high_q,
                               low_rate:  low_q,
                               notch_en:  c2_en_q[`ARC_NOTCH_BIT]};

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  sequence s_high_wr;
    reg_wr_i && reg_addr_i == `ARC_OFF_C2_HIGH;
  endsequence
  sequence s_high_rd;
    reg_rd_i && reg_addr_i == `ARC_OFF_C2_HIGH;
  endsequence
  sequence s_c1_wr;
    reg_wr_i && reg_addr_i == `ARC_OFF_C1_EN;
  endsequence
  sequence s_c2_en_wr;
    reg_wr_i && reg_addr_i == `ARC_OFF_C2_EN;
  endsequence

  a_high_rate_store: assert property (
    s_high_wr |=> high_q == $past(reg_wdata_i[14:11]))
    else $error("high rate not stored");
  a_low_rate_store: assert property (
    reg_wr_i && reg_addr_i == `ARC_OFF_C2_LOW
      |=> conv2_notch_cfg_o.low_rate == $past(reg_wdata_i[14:11]))
    else $error("low rate not stored");
  a_interp_enable: assert property (
    reg_wr_i && reg_addr_i == `ARC_OFF_C2_EN && clk_sufficient_i
      |=> conv2_path_o.interp_en == $past(reg_wdata_i[15:12]))
    else $error("interp enables wrong");
  a_decim_enable: assert property (
    reg_wr_i && reg_addr_i == `ARC_OFF_C2_EN && clk_sufficient_i
      |=> conv2_path_o.decim_en == $past(reg_wdata_i[9:6]))
    else $error("decim enables wrong");
  a_notch_enable: assert property (
    reg_wr_i && reg_addr_i == `ARC_OFF_C2_EN && clk_sufficient_i
      |=> conv2_path_o.notch_en == $past(reg_wdata_i[0]))
    else $error("notch enable wrong");
  a_conv1_decim: assert property (
    conv1_path_o.decim_en[3] == 1'b0 && conv1_path_o.interp_en == 4'h0)
    else $error("conv1 unused enables set");
  a_refuse_new: assert property (
    !clk_sufficient_i && !$rose(reset_i)
      |=> ($past(c2_en_q) | ~c2_en_q) == 16'hffff)
    else $error("path enabled while underclocked");
  a_notch_cfg: assert property (
    s_high_wr |=> conv2_notch_cfg_o.high_rate == $past(reg_wdata_i[14:11])
      && conv2_notch_cfg_o.notch_en == conv2_path_o.notch_en)
    else $error("notch config not from rate");
  a_high_readback: assert property (
    s_high_wr ##1 s_high_rd |=> reg_rdata_o == {1'b0, $past(high_q), 11'h000}
      && reg_rdata_o[15] == 1'b0 && reg_rdata_o[10:0] == 11'h000)
    else $error("high rate readback wrong");
  a_c1_store: assert property (
    s_c1_wr ##0 clk_sufficient_i
      |=> conv1_path_o.decim_en == {1'b0, $past(reg_wdata_i[8:6])}
      && conv1_path_o.notch_en == $past(reg_wdata_i[0]))
    else $error("conv1 enables not stored");
  a_c1_refuse: assert property (
    !clk_sufficient_i |=> ($past(c1_en_q) | ~c1_en_q) == 16'hffff)
    else $error("conv1 path enabled while underclocked");
  // A refused write must leave a trace for software
  a_err_refused: assert property (
    s_c2_en_wr ##0 (!clk_sufficient_i
      && (reg_wdata_i & `ARC_C2_EN_MASK & ~c2_en_q) != 16'h0000)
      |=> underclock_err_o)
    else $error("refused enable not flagged");
  a_err_cause: assert property (
    underclock_err_o |-> $past(reg_wr_i) && !$past(clk_sufficient_i))
    else $error("underclock flag without refused write");
  a_rdata_idle: assert property (
    !reg_rd_i |=> reg_rdata_o == 16'h0000)
    else $error("read data outside read cycle");
  a_low_readback: assert property (
    reg_rd_i && reg_addr_i == `ARC_OFF_C2_LOW
      |=> reg_rdata_o == {1'b0, $past(low_q), 11'h000})
    else $error("low rate readback wrong");

endmodule : arc_ctrl

// >>> arc_defs.svh
// Offsets, field positions and reset values of the rate converter controls
`ifndef ARC_DEFS_SVH
`define ARC_DEFS_SVH
`define ARC_ADDR_W        12
`define ARC_OFF_C1_EN     12'hef2
`define ARC_OFF_C2_HIGH   12'hef3
`define ARC_OFF_C2_LOW    12'hef4
`define ARC_OFF_C2_EN     12'hef5
`define ARC_RATE_MSB      14
`define ARC_RATE_LSB      11
`define ARC_INT_MSB       15
`define ARC_INT_LSB       12
`define ARC_DEC_MSB       9
`define ARC_DEC_LSB       6
`define ARC_C1_DEC_MSB    8
`define ARC_NOTCH_BIT     0
`define ARC_RATE_RST      4'h0
`define ARC_EN_RST        16'h0000
`define ARC_C1_EN_MASK    16'h01c1
`define ARC_C2_EN_MASK    16'hf3c1
`define ARC_RATE_MASK     16'h7800
`endif

// >>> arc_pkg.sv
// Types shared by the rate converter control registers
package arc_pkg;
  typedef enum logic [3:0] {
    ARC_SYNC_1  = 4'h0,
    ARC_SYNC_2  = 4'h1,
    ARC_SYNC_3  = 4'h2,
    ARC_ASYNC_1 = 4'h8,
    ARC_ASYNC_2 = 4'h9
  } arc_rate_e;
  typedef struct packed {
    logic [3:0] interp_en;
    logic [3:0] decim_en;
    logic       notch_en;
  } arc_path_s;
  typedef struct packed {
    logic [3:0] high_rate;
    logic [3:0] low_rate;
    logic       notch_en;
  } arc_notch_cfg_s;
endpackage : arc_pkg

// >>> tb_top.sv
// Self-checking bench for the rate converter control registers
`timescale 1ns/1ps
`include "arc_defs.svh"
module tb_top;
  import arc_pkg::*;
  logic           sys_clk_i        = 1'b0;
  logic           reset_i          = 1'b1;
  logic [11:0]    reg_addr_i       = 12'h000;
  logic [15:0]    reg_wdata_i      = 16'h0000;
  logic           reg_wr_i         = 1'b0;
  logic           reg_rd_i         = 1'b0;
  logic           clk_sufficient_i = 1'b1;
  logic [15:0]    reg_rdata_o;
  arc_path_s      conv1_path_o;
  arc_path_s      conv2_path_o;
  arc_notch_cfg_s conv2_notch_cfg_o;
  logic           underclock_err_o;
  int             n_errors = 0;
  int             compares = 0;
  logic [15:0]    rd;
  logic [3:0]     codes [5] = '{4'h0, 4'h1, 4'h2, 4'h8, 4'h9};
  logic [3:0]     lows  [5] = '{4'h2, 4'h1, 4'h0, 4'h9, 4'h8};
  always #25 sys_clk_i = ~sys_clk_i;
  arc_ctrl u_arc_ctrl (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .clk_sufficient_i(clk_sufficient_i), .conv1_path_o(conv1_path_o),
    .conv2_path_o(conv2_path_o), .conv2_notch_cfg_o(conv2_notch_cfg_o),
    .underclock_err_o(underclock_err_o));
  // ----------------------------------------
  // Bus tasks and comparison
  // ----------------------------------------
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge sys_clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i    <= 1'b0;
  endtask : wr
  // Read data only stand in the cycle after the strobe
  task automatic rdr(input logic [11:0] a, output logic [15:0] d);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_i   <= 1'b0;
    @(negedge sys_clk_i);
    d = reg_rdata_o;
  endtask : rdr
  // Write then read back with no gap between the strobes
  task automatic wr_rd(input logic [11:0] a, input logic [15:0] d,
                       output logic [15:0] q);
    @(posedge sys_clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i    <= 1'b0;
    reg_rd_i    <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_i    <= 1'b0;
    @(negedge sys_clk_i);
    q = reg_rdata_o;
  endtask : wr_rd
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    for (int i = 0; i < 4; i++) begin
      rdr(`ARC_OFF_C1_EN + 12'(i), rd);
      cmp(rd, 16'h0000);
    end
    rdr(12'hef6, rd);
    cmp(rd, 16'h0000);
    cmp({7'h0, conv1_path_o}, 16'h0000);
  endtask : t_reset
  // Only defined codes, both rates in one domain, sources left cleared
  task automatic t_rates;
    for (int i = 0; i < 5; i++) begin
      // legal high code, no source active
      wr_rd(`ARC_OFF_C2_HIGH, 16'h87ff | {1'b0, codes[i], 11'h0}, rd);
      cmp(rd, {1'b0, codes[i], 11'h0});
      // low rate changed with interpolation sources cleared
      wr(`ARC_OFF_C2_LOW, {1'b1, lows[i], 11'h7ff});
      rdr(`ARC_OFF_C2_HIGH, rd);
      cmp(rd, {1'b0, codes[i], 11'h0});
      rdr(`ARC_OFF_C2_LOW, rd);
      cmp(rd, {1'b0, lows[i], 11'h0});
      cmp({7'h0, conv2_notch_cfg_o}, {7'h0, codes[i], lows[i], 1'b0});
    end
  endtask : t_rates
  task automatic t_enables;
    wr(`ARC_OFF_C2_EN, 16'hffff);
    @(negedge sys_clk_i);
    cmp({7'h0, conv2_path_o}, 16'h01ff);
    cmp({7'h0, conv2_notch_cfg_o}, {7'h0, codes[4], lows[4], 1'b1});
    rdr(`ARC_OFF_C2_EN, rd);
    cmp(rd, 16'hf3c1);
    wr(`ARC_OFF_C1_EN, 16'hffff);
    rdr(`ARC_OFF_C1_EN, rd);
    cmp(rd, 16'h01c1);
    cmp({7'h0, conv1_path_o}, 16'h000f);
    wr(`ARC_OFF_C2_EN, 16'h4000);
    rdr(`ARC_OFF_C2_EN, rd);
    cmp(rd, 16'h4000);
  endtask : t_enables
  // New enables are refused when clocking is short, running ones stay
  task automatic t_underclock;
    @(posedge sys_clk_i);
    clk_sufficient_i <= 1'b0;
    wr(`ARC_OFF_C2_EN, 16'hc041);
    @(negedge sys_clk_i);
    cmp({15'h0, underclock_err_o}, 16'h0001);
    @(negedge sys_clk_i);
    cmp({15'h0, underclock_err_o}, 16'h0000);
    rdr(`ARC_OFF_C2_EN, rd);
    cmp(rd, 16'h4000);
    wr(`ARC_OFF_C2_EN, 16'h0000);
    @(negedge sys_clk_i);
    cmp({15'h0, underclock_err_o}, 16'h0000);
    cmp({7'h0, conv2_path_o}, 16'h0000);
    @(posedge sys_clk_i);
    clk_sufficient_i <= 1'b1;
  endtask : t_underclock
  task automatic final_report;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  initial begin
    #100000;
    n_errors++;
    final_report();
  end
  initial begin
    repeat (4) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    t_reset();
    t_rates();
    t_enables();
    t_underclock();
    final_report();
  end
endmodule : tb_top
